// ### drit_defs.vh
`ifndef DRIT_DEFS_VH
`define DRIT_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DRIT_OFS_CTRL_STAT 8'h00
`define DRIT_OFS_COUNTER 8'h04
`define DRIT_OFS_LIMIT 8'h08
`define DRIT_OFS_TALLY 8'h0C
`define DRIT_OFS_IRQ_STAT 8'h10
`define DRIT_OFS_IRQ_MASK 8'h14
`define DRIT_OFS_MEM_CTRL 8'h18

// ----------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------
`define DRIT_CS_MATCH_FLAG 7
`define DRIT_CS_MATCH_IE 6
`define DRIT_CS_CKSEL_HI 5
`define DRIT_CS_CKSEL_LO 3
`define DRIT_CS_OVF_FLAG 2
`define DRIT_CS_OVF_IE 1
`define DRIT_CS_LMT_SEL 0

// ----------------------------------------------------------------
// Memory control field positions
// ----------------------------------------------------------------
`define DRIT_MC_REFRESH_EN 0
`define DRIT_MC_CBR_MODE 1

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define DRIT_EV_MATCH 0
`define DRIT_EV_OVF 1
`define DRIT_EV_REFRESH 2
`define DRIT_EV_WIDTH 3

// ----------------------------------------------------------------
// Write keys and limits
// ----------------------------------------------------------------
`define DRIT_KEY_BYTE 8'hA5
`define DRIT_KEY_TALLY 6'h29
`define DRIT_TALLY_LIMIT_LONG 11'h400
`define DRIT_TALLY_LIMIT_SHORT 11'h200

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DRIT_RST_BYTE 8'h00
`define DRIT_RST_TALLY 10'h000
`define DRIT_RST_DIV 12'h000

`endif

// ### drit_prescaler.v
`timescale 1ns/100ps
`include "drit_defs.vh"

module drit_prescaler (
  input wire pclk,
  input wire presetn,
  input wire hold,
  input wire [2:0] sel,
  output reg tick
);

  reg [11:0] div;

  // Low bits of the divider that must all be ones for the chosen ratio
  function [11:0] drit_div_mask;
    input [2:0] s;
    begin
      case (s)
        3'h1: drit_div_mask = 12'h003;
        3'h2: drit_div_mask = 12'h00F;
        3'h3: drit_div_mask = 12'h03F;
        3'h4: drit_div_mask = 12'h0FF;
        3'h5: drit_div_mask = 12'h3FF;
        3'h6: drit_div_mask = 12'h7FF;
        3'h7: drit_div_mask = 12'hFFF;
        default: drit_div_mask = 12'h000;
      endcase
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= `DRIT_RST_DIV;
      tick <= 1'b0;
    end else if (hold) begin
      tick <= 1'b0;
    end else begin
      div <= div + 12'h001;
      // Zero select stops the count clock entirely
      tick <= (sel != 3'h0) &&
              ((div & drit_div_mask(sel)) == drit_div_mask(sel));
    end
  end

endmodule // drit_prescaler

// ### drit_tally.v
`timescale 1ns/100ps
`include "drit_defs.vh"

module drit_tally (
  input wire pclk,
  input wire presetn,
  input wire inc,
  input wire limit_sel,
  input wire wr_en,
  input wire [9:0] wr_data,
  output reg [9:0] count,
  output reg ovf
);

  wire [10:0] next_count;
  wire [10:0] limit;

  assign next_count = {1'b0, count} + 11'h001;
  assign limit = limit_sel ? `DRIT_TALLY_LIMIT_SHORT : `DRIT_TALLY_LIMIT_LONG;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `DRIT_RST_TALLY;
      ovf <= 1'b0;
    end else begin
      ovf <= 1'b0;
      if (wr_en) begin
        // A software write wins over a coincident match count
        count <= wr_data;
      end else if (inc) begin
        if (next_count >= limit) begin
          count <= `DRIT_RST_TALLY;
          ovf <= 1'b1;
        end else begin
          count <= next_count[9:0];
        end
      end
    end
  end

endmodule // drit_tally

// ### drit_refresh_timer.v
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "drit_defs.vh"


module drit_refresh_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire standby,
  output reg refresh_req,
  output reg irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] refresh_interval_counter;
  reg [7:0] refresh_interval_limit;
  reg match_flag;
  reg match_irq_enable;
  reg [2:0] count_clock_select;
  reg tally_overflow_flag;
  reg overflow_irq_enable;
  reg tally_limit_select;
  reg refresh_enable_bit;
  reg cbr_mode;
  reg [`DRIT_EV_WIDTH-1:0] irq_status;
  reg [`DRIT_EV_WIDTH-1:0] irq_mask;
  reg standby_meta;
  reg standby_sync;

  wire tick;
  wire [9:0] refresh_tally;
  wire tally_ovf;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire word_wr = wr && (pstrb[1:0] == 2'h3);
  wire key8_ok = pwdata[15:8] == `DRIT_KEY_BYTE;
  wire key6_ok = pwdata[15:10] == `DRIT_KEY_TALLY;
  wire mapped = (paddr == `DRIT_OFS_CTRL_STAT) || (paddr == `DRIT_OFS_COUNTER) ||
                (paddr == `DRIT_OFS_LIMIT) || (paddr == `DRIT_OFS_TALLY) ||
                (paddr == `DRIT_OFS_IRQ_STAT) || (paddr == `DRIT_OFS_IRQ_MASK) ||
                (paddr == `DRIT_OFS_MEM_CTRL);

  // Keyed writes to control/status, counter, limit and tally: wrong key or byte lanes leave the target untouched
  wire cs_wr = word_wr && key8_ok && (paddr == `DRIT_OFS_CTRL_STAT);
  wire cnt_wr = word_wr && key8_ok && (paddr == `DRIT_OFS_COUNTER);
  wire lim_wr = word_wr && key8_ok && (paddr == `DRIT_OFS_LIMIT);
  wire tal_wr = word_wr && key6_ok && (paddr == `DRIT_OFS_TALLY);
  wire ist_wr = wr && (paddr == `DRIT_OFS_IRQ_STAT);
  wire msk_wr = wr && (paddr == `DRIT_OFS_IRQ_MASK);
  wire mc_wr = wr && (paddr == `DRIT_OFS_MEM_CTRL);

  // ----------------------------------------------------------------
  // Count path
  // ----------------------------------------------------------------
  wire compare_eq = refresh_interval_counter == refresh_interval_limit;
  wire match_event = tick && compare_eq;
  wire refresh_event = match_event && refresh_enable_bit && cbr_mode;
  wire [`DRIT_EV_WIDTH-1:0] events = {refresh_event, tally_ovf, match_event};

  drit_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .hold(standby_sync),
    .sel(count_clock_select),
    .tick(tick)
  );

  drit_tally u_tally (
    .pclk(pclk),
    .presetn(presetn),
    .inc(match_event),
    .limit_sel(tally_limit_select),
    .wr_en(tal_wr),
    .wr_data(pwdata[9:0]),
    .count(refresh_tally),
    .ovf(tally_ovf)
  );

  // Standby is an asynchronous pin level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_meta <= 1'b0;
      standby_sync <= 1'b0;
    end else begin
      standby_meta <= standby;
      standby_sync <= standby_meta;
    end
  end

  // Manual reset has no port: nothing here is disturbed by it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_interval_counter <= `DRIT_RST_BYTE;
      refresh_interval_limit <= `DRIT_RST_BYTE;
    end else begin
      if (cnt_wr) begin
        refresh_interval_counter <= pwdata[7:0];
      end else if (match_event) begin
        refresh_interval_counter <= `DRIT_RST_BYTE;
      end else if (tick) begin
        // Ticks stop in standby, so the count holds there
        refresh_interval_counter <= refresh_interval_counter + 8'h01;
      end
      if (lim_wr) begin
        refresh_interval_limit <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control/status register
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag <= 1'b0;
      match_irq_enable <= 1'b0;
      count_clock_select <= 3'h0;
      tally_overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      tally_limit_select <= 1'b0;
    end else begin
      // Hardware set wins over a coincident zero write
      match_flag <= match_event ||
                    (match_flag && !(cs_wr && !pwdata[`DRIT_CS_MATCH_FLAG]));
      tally_overflow_flag <= tally_ovf ||
                    (tally_overflow_flag && !(cs_wr && !pwdata[`DRIT_CS_OVF_FLAG]));
      if (cs_wr) begin
        match_irq_enable <= pwdata[`DRIT_CS_MATCH_IE];
        count_clock_select <= pwdata[`DRIT_CS_CKSEL_HI:`DRIT_CS_CKSEL_LO];
        overflow_irq_enable <= pwdata[`DRIT_CS_OVF_IE];
        tally_limit_select <= pwdata[`DRIT_CS_LMT_SEL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory control, event status, mask, outputs
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_enable_bit <= 1'b0;
      cbr_mode <= 1'b0;
      irq_status <= {`DRIT_EV_WIDTH{1'b0}};
      irq_mask <= {`DRIT_EV_WIDTH{1'b0}};
      refresh_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (mc_wr) begin
        refresh_enable_bit <= pwdata[`DRIT_MC_REFRESH_EN];
        cbr_mode <= pwdata[`DRIT_MC_CBR_MODE];
      end
      if (msk_wr) begin
        irq_mask <= pwdata[`DRIT_EV_WIDTH-1:0];
      end
      // Write one to clear; a new event in the same cycle survives
      irq_status <= events |
                    (irq_status & ~(ist_wr ? pwdata[`DRIT_EV_WIDTH-1:0] :
                                    {`DRIT_EV_WIDTH{1'b0}}));
      refresh_req <= refresh_event;
      irq <= ((irq_status & irq_mask) != {`DRIT_EV_WIDTH{1'b0}}) ||
             (match_flag && match_irq_enable) ||
             (tally_overflow_flag && overflow_irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, registered read data
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `DRIT_OFS_CTRL_STAT: prdata[7:0] <= {match_flag, match_irq_enable,
            count_clock_select, tally_overflow_flag, overflow_irq_enable,
            tally_limit_select};
          `DRIT_OFS_COUNTER: prdata[7:0] <= refresh_interval_counter;
          `DRIT_OFS_LIMIT: prdata[7:0] <= refresh_interval_limit;
          `DRIT_OFS_TALLY: prdata[9:0] <= refresh_tally;
          `DRIT_OFS_IRQ_STAT: prdata[`DRIT_EV_WIDTH-1:0] <= irq_status;
          `DRIT_OFS_IRQ_MASK: prdata[`DRIT_EV_WIDTH-1:0] <= irq_mask;
          `DRIT_OFS_MEM_CTRL: prdata[1:0] <= {cbr_mode, refresh_enable_bit};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // drit_refresh_timer

// ### drit_refresh_sink.sv
`timescale 1ns/100ps
// ------------------------------------------------
// Refresh cycle generator stand-in
// ------------------------------------------------
module drit_refresh_sink (
  input wire pclk,
  input wire presetn,
  input wire refresh_req,
  output reg [15:0] refresh_cnt
);
  // One refresh cycle per sampled request; no handshake back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt <= 16'h0000;
    end else if (refresh_req) begin
      refresh_cnt <= refresh_cnt + 16'h0001;
    end
  end
endmodule // drit_refresh_sink

// ### drit_refresh_timer_props.sv
`timescale 1ns/100ps
module drit_refresh_timer_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire standby,
  input wire refresh_req,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------
  // Bus answer
  // ------------------------------------------------
  property p_ans;
    psel && penable && !pready |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("pready late");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  property p_rd_hi;
    pready && !pwrite && !pslverr && paddr != 8'h0C |-> prdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_rd_tally;
    pready && !pwrite && paddr == 8'h0C |-> prdata[31:10] == 22'h000000;
  endproperty
  a_rd_tally: assert property (p_rd_tally) else $error("tally upper bits set");
  property p_err;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  // ------------------------------------------------
  // Refresh and interrupt
  // ------------------------------------------------
  // Fastest count clock is a quarter of pclk, so pulses sit apart
  property p_req_pulse;
    refresh_req |=> !refresh_req [*3];
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("refresh pulse");
  property p_stby;
    standby [*5] |-> !refresh_req;
  endproperty
  a_stby: assert property (p_stby) else $error("refresh in standby");
  property p_rst;
    $rose(presetn) |-> !irq && !refresh_req && !pready;
  endproperty
  a_rst: assert property (p_rst) else $error("output after reset");
  property p_irq_fall;
    $fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  c_req: cover property (refresh_req);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule // drit_refresh_timer_props

bind drit_refresh_timer drit_refresh_timer_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .standby(standby),
  .refresh_req(refresh_req),
  .irq(irq)
);

// ### drit_refresh_timer_tb.sv
`timescale 1ns/100ps
module drit_refresh_timer_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h00000000;
  reg [3:0] pstrb = 4'h0;
  reg standby = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire refresh_req;
  wire irq;
  wire [15:0] refresh_cnt;
  reg [31:0] rdat;
  reg [31:0] v;
  reg [31:0] w;
  reg rerr;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer k;
  always #4 pclk = ~pclk;
  drit_refresh_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .refresh_req(refresh_req), .irq(irq));
  drit_refresh_sink sink (.pclk(pclk), .presetn(presetn),
    .refresh_req(refresh_req), .refresh_cnt(refresh_cnt));
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task stop_test;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (s !== x) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
    end
  endtask
  task apb(input [7:0] a, input wr_n, input [31:0] d, input [3:0] s);
    integer n;
    begin
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr_n;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n = n + 1;
      end
      // A slave that never answers is a failure, not a silent pass
      if (n >= 50) error_cnt = error_cnt + 1;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(a, 1'b1, d, 4'hF);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    begin
      apb(a, 1'b0, 32'h00000000, 4'h0);
      chk(rdat, x);
    end
  endtask
  task wait_irq(input x);
    begin
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, x});
    end
  endtask
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 16; k = k + 4) rd(k[7:0], 32'h00000000);
    rd(8'h1C, 32'h00000000);
    chk({31'h0, rerr}, 32'h00000001);
    wr(8'h08, 32'h00005A07);
    rd(8'h08, 32'h00000000);
    apb(8'h08, 1'b1, 32'h0000A507, 4'h1);
    rd(8'h08, 32'h00000000);
    wr(8'h08, 32'h0000A503);
    rd(8'h08, 32'h00000003);
    wr(8'h0C, 32'h00005555);
    rd(8'h0C, 32'h00000000);
    wr(8'h0C, 32'h0000A555);
    rd(8'h0C, 32'h00000155);
    wr(8'h04, 32'h0000A502);
    repeat (40) @(posedge pclk);
    rd(8'h04, 32'h00000002);
    wr(8'h18, 32'h00000003);
    wr(8'h00, 32'h0000A548);
    k = 0;
    while (refresh_req !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k = k + 1;
    end
    if (k >= 200) error_cnt = error_cnt + 1;
    v = refresh_cnt;
    // Limit 3 at divide by 4 gives one match every 16 clocks
    repeat (160) @(posedge pclk);
    chk({16'h0000, refresh_cnt} - v, 32'h0000000A);
    @(posedge pclk);
    rd(8'h0C, 32'h00000155 + {16'h0000, refresh_cnt});
    chk({31'h0, irq}, 32'h00000001);
    wr(8'h00, 32'h0000A5C0);
    rd(8'h00, 32'h000000C0);
    wr(8'h00, 32'h0000A540);
    rd(8'h00, 32'h00000040);
    wait_irq(1'b0);
    rd(8'h10, 32'h00000005);
    wr(8'h14, 32'h00000001);
    wait_irq(1'b1);
    wr(8'h10, 32'h00000007);
    wait_irq(1'b0);
    rd(8'h10, 32'h00000000);
    wr(8'h0C, 32'h0000A5FE);
    wr(8'h00, 32'h0000A50B);
    repeat (60) @(posedge pclk);
    wr(8'h00, 32'h0000A587);
    rd(8'h00, 32'h00000087);
    wait_irq(1'b1);
    apb(8'h0C, 1'b0, 32'h00000000, 4'h0);
    chk({31'h0, rdat < 32'h00000004}, 32'h00000001);
    wr(8'h0C, 32'h0000A5FE);
    wr(8'h00, 32'h0000A50A);
    repeat (60) @(posedge pclk);
    wr(8'h00, 32'h0000A506);
    rd(8'h00, 32'h00000002);
    wr(8'h18, 32'h00000001);
    wr(8'h00, 32'h0000A508);
    v = refresh_cnt;
    repeat (60) @(posedge pclk);
    chk({16'h0000, refresh_cnt} - v, 32'h00000000);
    wr(8'h18, 32'h00000003);
    standby <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(8'h04, 1'b0, 32'h00000000, 4'h0);
    w = rdat;
    v = refresh_cnt;
    repeat (80) @(posedge pclk);
    chk({16'h0000, refresh_cnt} - v, 32'h00000000);
    rd(8'h04, w);
    standby <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h08, 32'h00000000);
    rd(8'h00, 32'h00000000);
    stop_test;
  end
  // Whole sequence needs well under 3000 clocks
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule // drit_refresh_timer_tb
